// ---- core/saf_params.svh ----
// offsets, field positions, reset values and timing counts for the second alert register
`ifndef SAF_PARAMS_SVH
`define SAF_PARAMS_SVH

`define SAF_ALERT_TWO_ADDR 8'h1F
`define SAF_ALERT_TWO_RESET 8'h00
`define SAF_BIT_OTP_REC 7
`define SAF_BIT_LEVEL 6
`define SAF_BIT_TM1 5
`define SAF_BIT_WDT 4
`define SAF_BIT_GAP 3
`define SAF_CFG_OFF 3'h0
`define SAF_CLK_HZ 40000000
// base unit of timer one and watchdog, in microseconds per config step
`define SAF_TM1_UNIT_US 1000
`define SAF_WDT_UNIT_US 1000
// current-gap delays per 0x28[3:2] code, in microseconds
`define SAF_GAP_DLY0_US 1
`define SAF_GAP_DLY1_US 10
`define SAF_GAP_DLY2_US 100
`define SAF_GAP_DLY3_US 1000
`define SAF_US_TO_CYC(us) (((us) * (`SAF_CLK_HZ / 1000000)) < 1 ? 1 : ((us) * (`SAF_CLK_HZ / 1000000)))

`endif

// ---- core/saf_pkg.sv ----
// types of the second alert flag logic
package saf_pkg;

	// output phase tracked for the level flag
	typedef enum logic [1:0] {
		SAF_PH_OFF = 2'b00,
		SAF_PH_RAMP = 2'b01,
		SAF_PH_NORMAL = 2'b10,
		SAF_PH_TRANS = 2'b11
	} saf_phase_t;

	// analog and register inputs that feed the flags
	typedef struct packed {
		logic otp_fault;
		logic otp_recovered;
		logic output_enable;
		logic out_below_85;
		logic out_at_90;
		logic out_at_ovp;
		logic transition_active;
		logic transition_reached;
		logic adc_enable;
		logic [2:0] timer_one_cfg;
		logic [2:0] watchdog_cfg;
		logic watchdog_kick;
		logic [1:0] gap_delay_sel;
		logic [7:0] current_gap_threshold;
		logic [10:0] input_current_reading;
		logic [10:0] output_current_reading;
	} saf_inputs_t;

	// host write into the alert register
	typedef struct packed {
		logic wr_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} saf_write_t;

	// whole state of the block
	typedef struct packed {
		logic [7:0] flags;
		saf_phase_t phase;
		logic otp_pending;
		logic en_prev;
		logic reached_prev;
		logic [23:0] tm1_cnt;
		logic tm1_done;
		logic [23:0] wdt_cnt;
		logic wdt_done;
		logic [23:0] gap_cnt;
		logic alert_n;
		logic regs_default;
	} saf_state_t;

endpackage

// ---- core/saf_alert_two.sv ----
// second alert register: sticky flags, timers, watchdog and alert pin
//
// Function
// - bit 7 sets on over-temperature recovery
// - bit 7 clears by writing one or on watchdog timeout
// - level flag stays zero in good states
// - level flag sets on ramp, fault, transition
// - level flag clears by writing one or on watchdog timeout
// - timer one runs while config nonzero
// - watchdog counts while config nonzero, alert low
// - watchdog timeout sets flag, resets registers
// - watchdog flag clears by writing one
// - gap flag only while ADC enabled
// - gap flag after current excess persists
// - gap flag clears by writing one, once fault gone
`include "saf_params.svh"

module saf_alert_two #(
	parameter int TM1_UNIT_CYC = `SAF_US_TO_CYC(`SAF_TM1_UNIT_US),
	parameter int WDT_UNIT_CYC = `SAF_US_TO_CYC(`SAF_WDT_UNIT_US),
	parameter int GAP_DLY3_CYC = `SAF_US_TO_CYC(`SAF_GAP_DLY3_US)
) (
	input wire logic clock,
	input wire logic rst,
	input saf_pkg::saf_write_t host_write,
	input saf_pkg::saf_inputs_t sense,
	output logic [7:0] alert_status_two,
	output logic alert_n,
	output logic regs_default_pulse
);
	import saf_pkg::*;

	localparam logic [23:0] GAP_DLY0 = 24'(`SAF_US_TO_CYC(`SAF_GAP_DLY0_US));
	localparam logic [23:0] GAP_DLY1 = 24'(`SAF_US_TO_CYC(`SAF_GAP_DLY1_US));
	localparam logic [23:0] GAP_DLY2 = 24'(`SAF_US_TO_CYC(`SAF_GAP_DLY2_US));
	localparam logic [23:0] GAP_DLY3 = 24'(GAP_DLY3_CYC);

	saf_state_t state_reg;
	saf_state_t state_next;

	logic [7:0] clr_mask;
	logic [7:0] clr_ok;
	logic [8:0] gap_diff;
	logic gap_cond;
	logic [23:0] gap_limit;
	logic [23:0] tm1_limit;
	logic [23:0] wdt_limit;
	logic [7:0] set_mask;
	logic wdt_fire;

	// write-one-to-clear mask, only for a write to this register
	always_comb begin
		if (host_write.wr_en && host_write.addr == `SAF_ALERT_TWO_ADDR) begin
			clr_mask = host_write.wdata;
		end else begin
			clr_mask = 8'h00;
		end
	end

	// current gap compare; a negative gap never trips
	always_comb begin
		gap_diff = {1'b0, sense.input_current_reading[10:3]} - {1'b0, sense.output_current_reading[10:3]};
		gap_cond = sense.adc_enable && !gap_diff[8] && (gap_diff[7:0] > sense.current_gap_threshold);
		case (sense.gap_delay_sel)
			2'h0: gap_limit = GAP_DLY0;
			2'h1: gap_limit = GAP_DLY1;
			2'h2: gap_limit = GAP_DLY2;
			default: gap_limit = GAP_DLY3;
		endcase
		tm1_limit = 24'(TM1_UNIT_CYC * int'(sense.timer_one_cfg));
		wdt_limit = 24'(WDT_UNIT_CYC * int'(sense.watchdog_cfg));
	end

	// next state of flags, counters, phase and pin
	always_comb begin
		state_next = state_reg;
		set_mask = 8'h00;
		wdt_fire = 1'b0;
		// local copy so the decode process stays the only driver of clr_mask
		clr_ok = clr_mask;
		state_next.en_prev = sense.output_enable;
		state_next.reached_prev = sense.transition_reached;
		state_next.regs_default = 1'b0;

		// over-temperature: pending until recovery is seen
		if (sense.otp_fault) begin
			state_next.otp_pending = 1'b1;
		end else if (state_reg.otp_pending && sense.otp_recovered) begin
			state_next.otp_pending = 1'b0;
			set_mask[`SAF_BIT_OTP_REC] = 1'b1;
		end

		// output level phase tracking
		case (state_reg.phase)
			SAF_PH_OFF: begin
				if (sense.output_enable && !state_reg.en_prev) begin
					state_next.phase = SAF_PH_RAMP;
				end
			end
			SAF_PH_RAMP: begin
				if (!sense.output_enable) begin
					state_next.phase = SAF_PH_OFF;
				end else if (sense.out_at_90) begin
					set_mask[`SAF_BIT_LEVEL] = 1'b1;
					state_next.phase = SAF_PH_NORMAL;
				end
			end
			SAF_PH_NORMAL: begin
				if (!sense.output_enable) begin
					state_next.phase = SAF_PH_OFF;
				end else if (sense.transition_active) begin
					state_next.phase = SAF_PH_TRANS;
				end else if (sense.out_below_85 || sense.out_at_ovp) begin
					set_mask[`SAF_BIT_LEVEL] = 1'b1;
				end
			end
			SAF_PH_TRANS: begin
				// no flag while the target is not yet reached
				if (!sense.output_enable) begin
					state_next.phase = SAF_PH_OFF;
				end else if (sense.transition_reached && !state_reg.reached_prev) begin
					set_mask[`SAF_BIT_LEVEL] = 1'b1;
					state_next.phase = SAF_PH_NORMAL;
				end
			end
			default: begin
				state_next.phase = SAF_PH_OFF;
			end
		endcase

		// timer one: counts while configured, stops once done
		if (sense.timer_one_cfg == `SAF_CFG_OFF) begin
			state_next.tm1_cnt = 24'h000000;
			state_next.tm1_done = 1'b0;
		end else if (!state_reg.tm1_done) begin
			if (state_reg.tm1_cnt + 24'h000001 >= tm1_limit) begin
				state_next.tm1_done = 1'b1;
				set_mask[`SAF_BIT_TM1] = 1'b1;
			end else begin
				state_next.tm1_cnt = state_reg.tm1_cnt + 24'h000001;
			end
		end

		// watchdog: a kick restarts the count and releases a finished one
		if (sense.watchdog_cfg == `SAF_CFG_OFF || sense.watchdog_kick) begin
			state_next.wdt_cnt = 24'h000000;
			state_next.wdt_done = 1'b0;
		end else if (!state_reg.wdt_done) begin
			if (state_reg.wdt_cnt + 24'h000001 >= wdt_limit) begin
				state_next.wdt_done = 1'b1;
				wdt_fire = 1'b1;
				set_mask[`SAF_BIT_WDT] = 1'b1;
			end else begin
				state_next.wdt_cnt = state_reg.wdt_cnt + 24'h000001;
			end
		end

		// current gap must persist for the selected delay
		if (!gap_cond) begin
			state_next.gap_cnt = 24'h000000;
		end else if (state_reg.gap_cnt + 24'h000001 >= gap_limit) begin
			set_mask[`SAF_BIT_GAP] = 1'b1;
		end else begin
			state_next.gap_cnt = state_reg.gap_cnt + 24'h000001;
		end

		// clears are honoured only once the cause is over; sets win over clears
		if (!state_reg.tm1_done && sense.timer_one_cfg != `SAF_CFG_OFF) begin
			clr_ok[`SAF_BIT_TM1] = 1'b0;
		end
		if (!state_reg.wdt_done && sense.watchdog_cfg != `SAF_CFG_OFF) begin
			clr_ok[`SAF_BIT_WDT] = 1'b0;
		end
		if (gap_cond) begin
			clr_ok[`SAF_BIT_GAP] = 1'b0;
		end
		clr_ok[2:0] = 3'h0;
		state_next.flags = (state_reg.flags & ~clr_ok) | set_mask;

		// watchdog timeout returns every bit but its own to default
		if (wdt_fire) begin
			state_next.flags = (`SAF_ALERT_TWO_RESET & ~(8'h01 << `SAF_BIT_WDT)) | (8'h01 << `SAF_BIT_WDT);
			state_next.regs_default = 1'b1;
			state_next.phase = SAF_PH_OFF;
			state_next.otp_pending = 1'b0;
			state_next.tm1_cnt = 24'h000000;
			state_next.tm1_done = 1'b0;
			state_next.gap_cnt = 24'h000000;
		end

		// pin low on any set fault flag, unrecovered over-temperature or a running watchdog
		state_next.alert_n = !(state_next.otp_pending
			|| state_next.flags[`SAF_BIT_LEVEL]
			|| state_next.flags[`SAF_BIT_TM1]
			|| state_next.flags[`SAF_BIT_WDT]
			|| state_next.flags[`SAF_BIT_GAP]
			|| (sense.watchdog_cfg != `SAF_CFG_OFF));
	end

	// single state register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.flags <= `SAF_ALERT_TWO_RESET;
			state_reg.phase <= SAF_PH_OFF;
			state_reg.alert_n <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from the state register
	assign alert_status_two = state_reg.flags;
	assign alert_n = state_reg.alert_n;
	assign regs_default_pulse = state_reg.regs_default;

endmodule

// ---- dv/saf_alert_two_properties.sv ----
// port assertions for the second alert register
module saf_alert_two_properties
	import saf_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input saf_pkg::saf_write_t host_write,
	input saf_pkg::saf_inputs_t sense,
	input wire logic [7:0] alert_status_two,
	input wire logic alert_n,
	input wire logic regs_default_pulse
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	logic [7:0] st;
	logic [7:0] w1c;
	logic gap;
	// clear requests aimed here; a negative difference never trips
	assign st = alert_status_two;
	assign w1c = (host_write.wr_en && host_write.addr == 8'h1F) ? host_write.wdata : 8'h00;
	assign gap = sense.adc_enable && sense.gap_delay_sel == 2'h3
		&& sense.input_current_reading[10:3] > sense.output_current_reading[10:3]
		&& sense.input_current_reading[10:3] - sense.output_current_reading[10:3] > sense.current_gap_threshold;
	// watchdog armed from idle and left alone; gap held for the shortened delay
	sequence s_wd_arm;
		$past(sense.watchdog_cfg) == 3'h0 && sense.watchdog_cfg == 3'h1;
	endsequence
	sequence s_wd_run;
		(sense.watchdog_cfg == 3'h1 && !sense.watchdog_kick)[*4];
	endsequence
	sequence s_gap_hold;
		gap[*8];
	endsequence
	AST_OTP_SET: assert property ($rose(st[7]) |-> $past(sense.otp_recovered && !sense.otp_fault))
		else $error("recovery flag set without recovery");
	AST_OTP_HOLD: assert property ($fell(st[7]) |-> $past(w1c[7]) || regs_default_pulse)
		else $error("recovery flag dropped without clear");
	AST_FLAG_PIN: assert property (|st[6:3] |-> !alert_n)
		else $error("flag set but alert pin high");
	AST_LEVEL_HOLD: assert property ($fell(st[6]) |-> $past(w1c[6]) || regs_default_pulse)
		else $error("level flag dropped without clear");
	AST_WDT_PIN: assert property (sense.watchdog_cfg != 3'h0 |=> !alert_n)
		else $error("watchdog running but alert pin high");
	AST_WDT_TIME: assert property (s_wd_arm ##0 s_wd_run |-> ##[0:3] regs_default_pulse)
		else $error("watchdog timeout missing");
	AST_WDT_PULSE: assert property (regs_default_pulse |-> st[4] && !alert_n ##1 !regs_default_pulse)
		else $error("default pulse malformed");
	AST_GAP_ADC: assert property ($rose(st[3]) |-> $past(sense.adc_enable))
		else $error("gap flag set with adc off");
	AST_GAP_TIME: assert property (s_gap_hold |-> ##[0:1] st[3])
		else $error("gap flag late");
endmodule

// ---- dv/saf_host_model.sv ----
// host side model issuing single-byte register writes
module saf_host_model
	import saf_pkg::*;
(
	input wire logic clock,
	output saf_pkg::saf_write_t host_write
);
	timeunit 1ns;
	timeprecision 100ps;
	initial host_write = '0;
	// one-cycle strobe; address and data scrambled once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		host_write = '{wr_en: 1'b1, addr: a, wdata: d};
		@(negedge clock);
		host_write = '{wr_en: 1'b0, addr: ~a, wdata: ~d};
	endtask
endmodule

// ---- dv/saf_alert_two_tb_top.sv ----
// self-checking bench for the second alert register
module saf_alert_two_tb_top;
	import saf_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 1'b0;
	logic rst = 1'b1;
	saf_write_t host_write;
	saf_inputs_t sense = '0;
	logic [7:0] stat;
	logic alert_n;
	logic pulse;
	int n_mismatch = 0;
	int checked = 0;
	// 40 MHz clock
	always #12.5 clock = ~clock;
	// short unit counts keep the run small
	saf_alert_two #(.TM1_UNIT_CYC(4), .WDT_UNIT_CYC(4), .GAP_DLY3_CYC(8)) i_dut (.clock(clock), .rst(rst),
		.host_write(host_write), .sense(sense), .alert_status_two(stat), .alert_n(alert_n), .regs_default_pulse(pulse));
	saf_host_model i_host (.clock(clock), .host_write(host_write));
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic st(input logic [7:0] e);
		chk("alert_status_two", e, stat);
	endtask
	task automatic pin(input logic e);
		chk("alert_n", {7'h00, e}, {7'h00, alert_n});
	endtask
	task automatic stop_test();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic t_otp();
		sense.otp_fault = 1'b1;
		cyc(2);
		pin(1'b0);
		sense.otp_fault = 1'b0;
		sense.otp_recovered = 1'b1;
		cyc(2);
		sense.otp_recovered = 1'b0;
		st(8'h80);
		pin(1'b1);
		i_host.wr(8'h1F, 8'h7F);
		st(8'h80);
		i_host.wr(8'h1E, 8'h80);
		st(8'h80);
		i_host.wr(8'h1F, 8'h80);
		st(8'h00);
		$display("otp done");
	endtask
	task automatic t_level();
		sense.output_enable = 1'b1;
		cyc(2);
		st(8'h00);
		sense.out_at_90 = 1'b1;
		cyc(2);
		st(8'h40);
		i_host.wr(8'h1F, 8'h40);
		st(8'h00);
		pin(1'b1);
		sense.out_at_90 = 1'b0;
		sense.out_below_85 = 1'b1;
		cyc(2);
		sense.out_below_85 = 1'b0;
		sense.out_at_90 = 1'b1;
		cyc(2);
		st(8'h40);
		i_host.wr(8'h1F, 8'h40);
		st(8'h00);
		// transition: quiet until its target is reached
		sense.transition_active = 1'b1;
		cyc(2);
		st(8'h00);
		sense.transition_active = 1'b0;
		sense.transition_reached = 1'b1;
		cyc(2);
		st(8'h40);
		i_host.wr(8'h1F, 8'h40);
		st(8'h00);
		sense.transition_reached = 1'b0;
		$display("level done");
	endtask
	task automatic t_timer();
		sense.timer_one_cfg = 3'h2;
		cyc(4);
		st(8'h00);
		cyc(6);
		st(8'h20);
		pin(1'b0);
		// restart the count with the flag still up
		sense.timer_one_cfg = 3'h0;
		cyc(1);
		sense.timer_one_cfg = 3'h2;
		cyc(2);
		// clear while counting must be ignored
		i_host.wr(8'h1F, 8'h20);
		st(8'h20);
		cyc(8);
		i_host.wr(8'h1F, 8'h20);
		st(8'h00);
		sense.timer_one_cfg = 3'h0;
		$display("timer done");
	endtask
	task automatic t_gap();
		sense.current_gap_threshold = 8'h10;
		sense.gap_delay_sel = 2'h3;
		sense.input_current_reading = 11'h180;
		sense.output_current_reading = 11'h080;
		cyc(12);
		st(8'h00);
		sense.adc_enable = 1'b1;
		cyc(6);
		st(8'h00);
		cyc(4);
		st(8'h08);
		i_host.wr(8'h1F, 8'h08);
		st(8'h08);
		sense.input_current_reading = 11'h080;
		i_host.wr(8'h1F, 8'h08);
		st(8'h00);
		sense.adc_enable = 1'b0;
		$display("gap done");
	endtask
	task automatic t_wdt();
		sense.out_at_ovp = 1'b1;
		cyc(1);
		sense.out_at_ovp = 1'b0;
		sense.watchdog_cfg = 3'h1;
		cyc(1);
		st(8'h40);
		cyc(3);
		chk("regs_default_pulse", 8'h01, {7'h00, pulse});
		cyc(3);
		chk("regs_default_pulse", 8'h00, {7'h00, pulse});
		st(8'h10);
		pin(1'b0);
		sense.watchdog_cfg = 3'h0;
		i_host.wr(8'h1F, 8'h10);
		st(8'h00);
		pin(1'b1);
		$display("watchdog done");
	endtask
	// reset for 20 cycles, then scenarios in turn
	initial begin
		cyc(20);
		rst = 1'b0;
		cyc(1);
		st(8'h00);
		pin(1'b1);
		t_otp();
		t_level();
		t_timer();
		t_gap();
		t_wdt();
		stop_test();
	end
	// hang guard, far past the hundred or so cycles the scenarios need
	initial begin
		#(25 * 3000);
		n_mismatch++;
		stop_test();
	end
endmodule
bind saf_alert_two saf_alert_two_properties i_props (.clock(clock), .rst(rst), .host_write(host_write),
	.sense(sense), .alert_status_two(alert_status_two), .alert_n(alert_n), .regs_default_pulse(regs_default_pulse));
